// ==== hw/arf_pkg.sv ====
// Package for the converter result and control register block.
// Assumes a 32-bit APB bus whose byte addresses are given below.
package arf_pkg;
  localparam int ADDR_W = 5;
  localparam int RES_W = 10;
  localparam int BYTE_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL_ZERO = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIG_CTRL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RES_HIGH = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_RES_LOW = 5'h10;
  // Field positions inside the control registers.
  localparam int BIT_ENABLE = 0;
  localparam int BIT_GO = 1;
  localparam int CHAN_LSB = 2;
  localparam int CHAN_MSB = 6;
  localparam int BIT_JUSTIFY = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int CLKSEL_MSB = 6;
  localparam int PREF_LSB = 0;
  localparam int PREF_MSB = 1;
  localparam int TRIG_LSB = 4;
  localparam int TRIG_MSB = 6;
  // Writable masks; unimplemented bits read as zero.
  localparam logic [BYTE_W-1:0] MASK_CTRL_ZERO = 8'h7F;
  localparam logic [BYTE_W-1:0] MASK_CTRL_ONE = 8'hF3;
  localparam logic [BYTE_W-1:0] MASK_TRIG_CTRL = 8'h70;
  localparam logic [BYTE_W-1:0] RST_CTRL = 8'h00;
  // Number of zero-filled bits in the unused part of a result byte.
  localparam int PAD_W = 2 * BYTE_W - RES_W;
endpackage : arf_pkg

// ==== hw/arf_result_pack.sv ====
// Places a 10-bit conversion result into a high and a low result byte.
// Assumes the caller registers both outputs in one cycle.
`timescale 1ns/1ps
module arf_result_pack (
  input wire logic [arf_pkg::RES_W-1:0] result_i,
  input wire logic justify_i,
  output logic [arf_pkg::BYTE_W-1:0] high_o,
  output logic [arf_pkg::BYTE_W-1:0] low_o
);
  localparam int PW = arf_pkg::PAD_W;
  localparam int BW = arf_pkg::BYTE_W;
  localparam int LW = arf_pkg::RES_W - BW;
  wire [BW-1:0] right_high = {{PW{1'b0}}, result_i[arf_pkg::RES_W-1:BW]};
  wire [BW-1:0] right_low = result_i[BW-1:0];
  wire [BW-1:0] left_high = result_i[arf_pkg::RES_W-1:LW];
  wire [BW-1:0] left_low = {result_i[LW-1:0], {PW{1'b0}}};
  assign high_o = justify_i ? right_high : left_high;
  assign low_o = justify_i ? right_low : left_low;
endmodule : arf_result_pack

// ==== hw/arf_top.sv ====
// Converter control and result registers behind an APB slave.
// Assumes a sequencer on mclk_i that starts on go_o and pulses conv_done_i with the result.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module arf_top #(
  parameter int RES_W = arf_pkg::RES_W
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic conv_done_i,
  input wire logic [RES_W-1:0] conversion_result_i,
  output logic converter_enable_o,
  output logic go_o,
  output logic [4:0] channel_select_o,
  output logic justify_select_o,
  output logic [2:0] conversion_clock_select_o,
  output logic [1:0] positive_reference_select_o,
  output logic [2:0] auto_trigger_select_o
);
  localparam int BW = arf_pkg::BYTE_W;
  localparam int AW = arf_pkg::ADDR_W;

  logic [BW-1:0] ctrl_zero;
  logic [BW-1:0] ctrl_one;
  logic [BW-1:0] trig_ctrl;
  logic [BW-1:0] result_high_byte;
  logic [BW-1:0] result_low_byte;
  logic [BW-1:0] packed_high;
  logic [BW-1:0] packed_low;
  logic [31:0] next_prdata;
  logic next_slverr;

  // Any nonzero upper address bit makes the access unmapped, so no register has aliases.
  function automatic logic reg_hit(input logic [31:0] a, input logic [AW-1:0] ofs);
    reg_hit = (a[31:AW] == '0) && (a[AW-1:0] == ofs);
  endfunction : reg_hit

  wire hit_c0 = reg_hit(paddr_i, arf_pkg::OFS_CTRL_ZERO);
  wire hit_c1 = reg_hit(paddr_i, arf_pkg::OFS_CTRL_ONE);
  wire hit_c2 = reg_hit(paddr_i, arf_pkg::OFS_TRIG_CTRL);
  wire hit_rh = reg_hit(paddr_i, arf_pkg::OFS_RES_HIGH);
  wire hit_rl = reg_hit(paddr_i, arf_pkg::OFS_RES_LOW);
  wire hit_any = hit_c0 || hit_c1 || hit_c2 || hit_rh || hit_rl;
  wire setup = psel_i && !penable_i;
  wire wr = psel_i && penable_i && pwrite_i && hit_any;
  wire [BW-1:0] wbyte = pwdata_i[BW-1:0];
  // A finished conversion is loaded only while a conversion is outstanding.
  wire load = conv_done_i && ctrl_zero[arf_pkg::BIT_GO];
  wire sw_start = wr && hit_c0 && wbyte[arf_pkg::BIT_GO];

  arf_result_pack u_pack (
    .result_i(conversion_result_i),
    .justify_i(ctrl_one[arf_pkg::BIT_JUSTIFY]),
    .high_o(packed_high),
    .low_o(packed_low)
  );

  wire [BW-1:0] rd_byte = hit_c0 ? ctrl_zero :
                          hit_c1 ? ctrl_one :
                          hit_c2 ? trig_ctrl :
                          hit_rh ? result_high_byte :
                          hit_rl ? result_low_byte : '0;

  assign next_prdata = {{(32 - BW){1'b0}}, rd_byte};
  assign next_slverr = !hit_any;
  // The slave never stalls, so every access phase completes at its first edge.
  assign pready_o = 1'b1;

  // Read data is latched in the setup phase so the bus sees it from a flip-flop.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? '0 : next_prdata;
      pslverr_o <= next_slverr;
    end
  end

  // A start written in the completion cycle wins, so a new conversion is never lost.
  wire [BW-1:0] next_ctrl_zero =
    (wr && hit_c0) ? (wbyte & arf_pkg::MASK_CTRL_ZERO) :
    load ? (ctrl_zero & ~(8'h01 << arf_pkg::BIT_GO)) : ctrl_zero;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_zero <= arf_pkg::RST_CTRL;
      ctrl_one <= arf_pkg::RST_CTRL;
      trig_ctrl <= arf_pkg::RST_CTRL;
    end else begin
      ctrl_zero <= next_ctrl_zero;
      if (wr && hit_c1) begin
        ctrl_one <= wbyte & arf_pkg::MASK_CTRL_ONE;
      end
      if (wr && hit_c2) begin
        trig_ctrl <= wbyte & arf_pkg::MASK_TRIG_CTRL;
      end
    end
  end

  // Result bytes carry no reset so they keep their contents across reset.
  // A load wins over a software write in the same cycle so the two bytes stay paired.
  always_ff @(posedge mclk_i) begin
    if (load) begin
      result_high_byte <= packed_high;
      result_low_byte <= packed_low;
    end else begin
      if (wr && hit_rh) begin
        result_high_byte <= wbyte;
      end
      if (wr && hit_rl) begin
        result_low_byte <= wbyte;
      end
    end
  end

  assign converter_enable_o = ctrl_zero[arf_pkg::BIT_ENABLE];
  assign go_o = ctrl_zero[arf_pkg::BIT_GO];
  assign channel_select_o = ctrl_zero[arf_pkg::CHAN_MSB:arf_pkg::CHAN_LSB];
  assign justify_select_o = ctrl_one[arf_pkg::BIT_JUSTIFY];
  assign conversion_clock_select_o = ctrl_one[arf_pkg::CLKSEL_MSB:arf_pkg::CLKSEL_LSB];
  assign positive_reference_select_o = ctrl_one[arf_pkg::PREF_MSB:arf_pkg::PREF_LSB];
  assign auto_trigger_select_o = trig_ctrl[arf_pkg::TRIG_MSB:arf_pkg::TRIG_LSB];

  // Checks on the result path and the go bit.
  wire justify = ctrl_one[arf_pkg::BIT_JUSTIFY];

  a_right_high: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && justify |=> result_high_byte == {6'h00, $past(conversion_result_i[9:8])})
    else $error("right justified high byte wrong");
  a_right_low: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && justify |=> result_low_byte == $past(conversion_result_i[7:0]))
    else $error("right justified low byte wrong");
  a_left_pad: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && !justify |=> result_low_byte[5:0] == 6'h00)
    else $error("left justified low padding not zero");
  a_left_code: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && !justify |=> {result_high_byte, result_low_byte[7:6]} == $past(conversion_result_i))
    else $error("left justified code lost bits");
  a_go_clears: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && !sw_start |=> !go_o)
    else $error("go bit not cleared after load");
  a_go_holds: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    go_o && !conv_done_i && !(wr && hit_c0) |=> go_o)
    else $error("go bit dropped without completion");
  a_sw_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr && hit_rh && !load |=> result_high_byte == $past(pwdata_i[7:0]))
    else $error("result high byte write lost");
  a_both_bytes: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load |=> {result_high_byte, result_low_byte} == ($past(justify) ?
      {6'h00, $past(conversion_result_i)} : {$past(conversion_result_i), 6'h00}))
    else $error("result bytes not loaded together");
  a_right_pad: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && justify |=> result_high_byte[7:2] == 6'h00)
    else $error("right justified high padding not zero");
  a_right_code: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && justify |=> {result_high_byte[1:0], result_low_byte} == $past(conversion_result_i))
    else $error("right justified code lost bits");
  a_left_high: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && !justify |=> result_high_byte == $past(conversion_result_i[9:2]))
    else $error("left justified high byte wrong");
  a_go_start: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    sw_start |=> go_o)
    else $error("go bit not set by software start");
  a_go_write_wins: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    load && wr && hit_c0 |=> go_o == $past(wbyte[arf_pkg::BIT_GO]))
    else $error("software write lost against hardware clear");
  a_done_refused: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    conv_done_i && !go_o && !wr |=> $stable(result_high_byte) && $stable(result_low_byte))
    else $error("result changed with no conversion in progress");
  a_low_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr && hit_rl && !load |=> result_low_byte == $past(pwdata_i[7:0]))
    else $error("result low byte write lost");

  // Bus answer and register masks.
  a_unmapped_err: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    setup && !hit_any |=> pslverr_o)
    else $error("unmapped access not flagged");
  a_mapped_ok: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    setup && hit_any |=> !pslverr_o)
    else $error("mapped access flagged as error");
  a_write_rdata: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    setup && pwrite_i |=> prdata_o == '0)
    else $error("read data not zero during write");
  a_read_ctrl: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    setup && !pwrite_i && hit_c0 |=> prdata_o == 32'($past(ctrl_zero)))
    else $error("control zero read data wrong");
  a_ctrl_zero_mask: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ctrl_zero & ~arf_pkg::MASK_CTRL_ZERO) == '0)
    else $error("control zero unimplemented bit set");
  a_ctrl_one_mask: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ctrl_one & ~arf_pkg::MASK_CTRL_ONE) == '0)
    else $error("control one unimplemented bit set");
  a_trig_mask: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (trig_ctrl & ~arf_pkg::MASK_TRIG_CTRL) == '0)
    else $error("trigger control unimplemented bit set");

  // Main scenarios: loads in both formats, a completed start, a refused done, a byte write.
  c_right_load: cover property (@(posedge mclk_i) disable iff (!arst_n_i) load && justify);
  c_left_load: cover property (@(posedge mclk_i) disable iff (!arst_n_i) load && !justify);
  c_start_done: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    sw_start ##[1:50] load);
  c_refused_done: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    conv_done_i && !go_o);
  c_result_write: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    wr && (hit_rh || hit_rl));
endmodule : arf_top

// ==== bench/testbench.sv ====
// Self-checking bench for the converter result and control register block.
// Assumes zero-wait APB and a one-cycle done pulse on the same clock.
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic conv_done_i = 1'b0;
  logic [9:0] conversion_result_i = 10'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, converter_enable_o, go_o, justify_select_o;
  logic [4:0] channel_select_o;
  logic [2:0] conversion_clock_select_o, auto_trigger_select_o;
  logic [1:0] positive_reference_select_o;
  int num_errors = 0;
  int n_compared = 0;
  localparam logic [31:0] A_C0 = 32'(arf_pkg::OFS_CTRL_ZERO);
  localparam logic [31:0] A_C1 = 32'(arf_pkg::OFS_CTRL_ONE);
  localparam logic [31:0] A_TR = 32'(arf_pkg::OFS_TRIG_CTRL);
  localparam logic [31:0] A_HI = 32'(arf_pkg::OFS_RES_HIGH);
  localparam logic [31:0] A_LO = 32'(arf_pkg::OFS_RES_LOW);
  logic [10:0] cases [5] = '{11'h7FF, 11'h400, 11'h3FF, 11'h2A5, 11'h555};
  // Stands for the acquisition interval that software allows after a channel change.
  localparam int ACQ_CYCLES = 16;
  always #5 mclk_i = ~mclk_i;
  arf_top DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .conv_done_i(conv_done_i), .conversion_result_i(conversion_result_i),
    .converter_enable_o(converter_enable_o), .go_o(go_o), .channel_select_o(channel_select_o),
    .justify_select_o(justify_select_o),
    .conversion_clock_select_o(conversion_clock_select_o),
    .positive_reference_select_o(positive_reference_select_o),
    .auto_trigger_select_o(auto_trigger_select_o));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // The leading edge keeps a release and the next setup in different time steps.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) begin
      @(posedge mclk_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] wd, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
    chk("write error", {31'h0, exp_err}, {31'h0, err});
  endtask : wr
  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic err;
    apb(1'b0, a, 32'h0, d, err);
    chk(what, exp, d);
  endtask : rd
  task automatic pulse(input logic [9:0] code);
    @(posedge mclk_i);
    conv_done_i <= 1'b1;
    conversion_result_i <= code;
    @(posedge mclk_i);
    conv_done_i <= 1'b0;
    conversion_result_i <= ~code;
    @(negedge mclk_i);
  endtask : pulse
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    logic [9:0] c;
    logic j;
    logic [7:0] hi, lo;
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rd("ctrl zero", A_C0, 32'h0);
    wr(A_C1, 32'hFF, 1'b0);
    @(negedge mclk_i);
    chk("justify pin", 32'h1, {31'h0, justify_select_o});
    chk("clock select pin", 32'h7, {29'h0, conversion_clock_select_o});
    chk("reference pin", 32'h3, {30'h0, positive_reference_select_o});
    rd("ctrl one mask", A_C1, 32'hF3);
    wr(A_TR, 32'hFF, 1'b0);
    @(negedge mclk_i);
    chk("trigger pin", 32'h7, {29'h0, auto_trigger_select_o});
    rd("trigger mask", A_TR, 32'h70);
    wr(32'h14, 32'hFF, 1'b1);
    rd("unmapped", 32'h14, 32'h0);
    for (int i = 0; i < 5; i++) begin
      {j, c} = cases[i];
      hi = j ? {6'h0, c[9:8]} : c[9:2];
      lo = j ? c[7:0] : {c[1:0], 6'h0};
      wr(A_C1, {24'h0, j, 7'h0}, 1'b0);
      wr(A_C0, 32'h7D, 1'b0);
      @(negedge mclk_i);
      chk("enable pin", 32'h1, {31'h0, converter_enable_o});
      chk("channel pin", 32'h1F, {27'h0, channel_select_o});
      chk("go idle", 32'h0, {31'h0, go_o});
      repeat (ACQ_CYCLES) @(posedge mclk_i);
      wr(A_C0, 32'h7F, 1'b0);
      @(negedge mclk_i);
      chk("go set", 32'h1, {31'h0, go_o});
      pulse(c);
      chk("go clear", 32'h0, {31'h0, go_o});
      pulse(~c);
      rd("high", A_HI, {24'h0, hi});
      rd("low", A_LO, {24'h0, lo});
    end
    wr(A_HI, 32'h5A, 1'b0);
    wr(A_LO, 32'hA5, 1'b0);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk("pins after reset", 32'h0, {16'h0, converter_enable_o, go_o, channel_select_o,
      justify_select_o, conversion_clock_select_o, positive_reference_select_o,
      auto_trigger_select_o});
    rd("ctrl after reset", A_C0, 32'h0);
    rd("high kept", A_HI, 32'h5A);
    rd("low kept", A_LO, 32'hA5);
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule : testbench
